// >>> design/walker_consts.vh
// Constants of the second-level page walker: register map, field
// positions, reset values, fault codes and entry layout.
// Assumes inclusion by every design file of the walker.
`ifndef WALKER_CONSTS_VH
`define WALKER_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL      8'h00
`define OFS_CAP       8'h04
`define OFS_ROOT_LO   8'h08
`define OFS_ROOT_HI   8'h0C
`define OFS_STATUS    8'h10
`define OFS_XL_CNT    8'h14
`define OFS_FLT_CNT   8'h18

// ****************************************
// Control fields and reset values
// ****************************************
`define CTRL_EN       0
`define CTRL_RECOV    1
`define CTRL_RST      2'h0
`define ROOT_RST      40'h00_0000_0000

// ****************************************
// Entry fields
// ****************************************
`define ENT_R         0
`define ENT_W         1
`define ENT_PS        7
`define ENT_SNP       11
`define ENT_TM        62
`define CTX_TT_BLOCK  2'h2
`define CTX_TT_BAD    2'h3

// ****************************************
// Request kinds, page sizes, fault codes
// ****************************************
`define KIND_RD       2'h0
`define KIND_WR       2'h1
`define KIND_AT       2'h2
`define PG_4K         2'h0
`define PG_2M         2'h1
`define PG_1G         2'h2
`define FLT_NONE      4'h0
`define FLT_WIDTH     4'h1
`define FLT_FETCH     4'h2
`define FLT_ROOT      4'h3
`define FLT_CTX       4'h4
`define FLT_RANGE     4'h5
`define FLT_ENTRY     4'h6
`define FLT_RIGHTS    4'h7

`endif

// >>> design/width_adjust.v
// Rounds a domain width up to the adjusted width and walk depth.
// Assumes a combinational use from a registered domain width.
`timescale 1ns/1ps
`include "walker_consts.vh"

module width_adjust (
    // Domain width in
    input  wire [6:0] domain_width,
    // Adjusted width and level count out
    output wire [7:0] adjusted_domain_width,
    output wire [3:0] levels
);
    wire [7:0] over;
    wire [7:0] steps;

    // Nine-bit strides above the 12-bit page offset
    assign over  = (domain_width > 7'h0C) ? ({1'b0, domain_width} - 8'h0C) : 8'h00;
    assign steps = (over + 8'h08) / 8'h09;
    assign adjusted_domain_width = 8'h0C + steps * 8'h09;
    assign levels = steps[3:0];
endmodule // width_adjust

// >>> design/entry_check.v
// Checks one second-level entry for presence, page mapping and reserved
// bits. Assumes level 4..1 where 1 is the leaf table.
`timescale 1ns/1ps
`include "walker_consts.vh"

module entry_check (
    // Entry and its level
    input  wire [63:0] entry,
    input  wire [2:0]  level,
    // Capabilities
    input  wire [6:0]  host_width,
    input  wire        cap_1g,
    input  wire        cap_2m,
    input  wire        cap_sc,
    input  wire        cap_dt,
    // Results
    output wire        present,
    output wire        is_page,
    output wire        rsv_err
);
    wire        ps;
    wire        snoop_flag;
    wire        tm;
    wire        nonleaf;
    wire [51:0] hmask;
    wire        rsv_hi;
    wire        rsv_ps;
    wire        rsv_big;
    wire        rsv_flags;

    // Execute flag (bit 2) is never looked at
    assign present = entry[`ENT_R] | entry[`ENT_W];
    assign ps      = entry[`ENT_PS];
    assign snoop_flag     = entry[`ENT_SNP];
    assign tm      = entry[`ENT_TM];
    assign is_page = (level == 3'd1) | (ps & ((level == 3'd3) | (level == 3'd2)));
    assign nonleaf = (level == 3'd4) | (~ps & ((level == 3'd3) | (level == 3'd2)));

    // Reserved-bit checks, valid only for present entries
    assign hmask   = {52{1'b1}} << host_width;
    assign rsv_hi  = |(entry[51:0] & hmask);
    assign rsv_ps  = ps & ((level == 3'd4)
                   | ((level == 3'd3) & ~cap_1g) | ((level == 3'd2) & ~cap_2m));
    assign rsv_big = ps & (((level == 3'd3) & (|entry[29:12]))
                   | ((level == 3'd2) & (|entry[20:12])));
    assign rsv_flags = (nonleaf & (snoop_flag | tm))
                     | ((level == 3'd1) & ((~cap_sc & snoop_flag) | (~cap_dt & tm)));
    assign rsv_err = present & (rsv_hi | rsv_ps | rsv_big | rsv_flags);
endmodule // entry_check

// >>> design/second_level_page_walker.v
// Second-level page walker with AHB-Lite registers, a request port for
// untagged DMA requests and a single-outstanding memory fetch port.
// Assumes the memory answers each fetch with one mem_ack pulse.
`timescale 1ns/1ps
`include "walker_consts.vh"

module second_level_page_walker #(
    parameter [7:0] MAX_IN_W = 8'd48,
    parameter [6:0] HOST_W   = 7'd46,
    parameter [0:0] CAP_1G   = 1'b1,
    parameter [0:0] CAP_2M   = 1'b1,
    parameter [0:0] CAP_SC   = 1'b1,
    parameter [0:0] CAP_DT   = 1'b0,
    parameter [0:0] CAP_3L   = 1'b1,
    parameter [0:0] CAP_4L   = 1'b1,
    parameter [0:0] CAP_PRS  = 1'b1
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output reg  [31:0] hrdata,
    output wire        hresp,
    // Translation request
    input  wire        req_valid,
    output wire        req_ready,
    input  wire [63:0] req_addr,
    input  wire [15:0] req_source,
    input  wire [1:0]  req_kind,
    input  wire        req_prs,
    // Translation answer
    output reg         rsp_valid,
    output reg  [51:0] rsp_addr,
    output reg         rsp_fault,
    output reg  [3:0]  rsp_fault_code,
    output reg         rsp_recoverable,
    output reg  [1:0]  rsp_page_size,
    // Table fetch
    output reg         mem_req,
    output reg  [51:0] mem_addr,
    input  wire        mem_ack,
    input  wire [63:0] mem_rdata,
    input  wire        mem_err
);
    // ****************************************
    // States
    // ****************************************
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_ROOT = 3'd1;
    localparam [2:0] S_CTXL = 3'd2;
    localparam [2:0] S_CTXH = 3'd3;
    localparam [2:0] S_CHK  = 3'd4;
    localparam [2:0] S_WALK = 3'd5;

    // ****************************************
    // Declarations
    // ****************************************
    reg  [2:0]  state;
    reg  [1:0]  ctrl;
    reg  [39:0] root_base;
    reg  [31:0] xl_cnt;
    reg  [31:0] flt_cnt;
    reg  [3:0]  last_fault;
    reg         a_wr;
    reg  [7:0]  a_off;
    reg  [31:0] rd_mux;
    reg  [63:0] lat_addr;
    reg  [15:0] lat_src;
    reg  [1:0]  lat_kind;
    reg         lat_prs;
    reg  [39:0] ctx_ptr;
    reg  [39:0] tbl_root;
    reg  [6:0]  domain_width;
    reg  [2:0]  lvl;
    reg         perm_r;
    reg         perm_w;
    reg         issue;
    reg         fin;
    reg  [3:0]  fcode;
    reg  [51:0] paddr;
    reg  [1:0]  psize;
    reg  [2:0]  next_state;
    reg  [51:0] next_mem_addr;
    reg         next_issue;
    wire        ahb_go;
    wire        enable;
    wire [51:0] hmask;
    wire [7:0]  adj_w;
    wire [3:0]  levels;
    wire [7:0]  xw;
    wire        ent_present;
    wire        ent_page;
    wire        ent_rsv;
    wire        pr;
    wire        pw;
    wire        rights_ok;
    wire [3:0]  root_lvl;

    // ****************************************
    // Sub-blocks
    // ****************************************
    width_adjust u_width (
        .domain_width          (domain_width),
        .adjusted_domain_width (adj_w),
        .levels                (levels)
    );

    entry_check u_check (
        .entry      (mem_rdata),
        .level      (lvl),
        .host_width (HOST_W),
        .cap_1g     (CAP_1G),
        .cap_2m     (CAP_2M),
        .cap_sc     (CAP_SC),
        .cap_dt     (CAP_DT),
        .present    (ent_present),
        .is_page    (ent_page),
        .rsv_err    (ent_rsv)
    );

    // Index bits of the input address for a table level
    function [8:0] idx_of;
        input [2:0]  l;
        input [63:0] a;
        begin
            case (l)
                3'd4:    idx_of = a[47:39];
                3'd3:    idx_of = a[38:30];
                3'd2:    idx_of = a[29:21];
                default: idx_of = a[20:12];
            endcase
        end
    endfunction

    // ****************************************
    // Bus slave
    // ****************************************
    // Zero wait state, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ahb_go    = hsel & htrans[1] & hready;
    assign enable    = ctrl[`CTRL_EN];

    // Read data selected in the address phase
    always @* begin
        case (haddr[7:0])
            `OFS_CTRL:    rd_mux = {30'h0, ctrl};
            `OFS_CAP:     rd_mux = {9'h000, CAP_PRS, CAP_4L, CAP_3L, CAP_DT, CAP_SC,
                                    CAP_2M, CAP_1G, 1'b0, HOST_W, MAX_IN_W};
            `OFS_ROOT_LO: rd_mux = {root_base[19:0], 12'h000};
            `OFS_ROOT_HI: rd_mux = {12'h000, root_base[39:20]};
            `OFS_STATUS:  rd_mux = {20'h0, last_fault, 7'h00, state != S_IDLE};
            `OFS_XL_CNT:  rd_mux = xl_cnt;
            `OFS_FLT_CNT: rd_mux = flt_cnt;
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // Address phase capture and data phase write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_wr      <= 1'b0;
            a_off     <= 8'h00;
            hrdata    <= 32'h0000_0000;
            ctrl      <= `CTRL_RST;
            root_base <= `ROOT_RST;
        end else begin
            if (ahb_go) begin
                a_wr  <= hwrite;
                a_off <= haddr[7:0];
                if (!hwrite) begin
                    hrdata <= rd_mux;
                end
            end else begin
                a_wr <= 1'b0;
            end
            if (a_wr) begin
                case (a_off)
                    `OFS_CTRL:    ctrl <= hwdata[1:0];
                    `OFS_ROOT_LO: root_base[19:0] <= hwdata[31:12];
                    `OFS_ROOT_HI: root_base[39:20] <= hwdata[19:0];
                    default:      ctrl <= ctrl;
                endcase
            end
        end
    end

    // ****************************************
    // Walk decisions
    // ****************************************
    assign req_ready = (state == S_IDLE) & enable;
    assign hmask     = {52{1'b1}} << HOST_W;
    assign xw        = (MAX_IN_W < adj_w) ? MAX_IN_W : adj_w;
    assign root_lvl  = levels;
    assign pr        = perm_r & mem_rdata[`ENT_R];
    assign pw        = perm_w & mem_rdata[`ENT_W];
    assign rights_ok = (lat_kind == `KIND_RD) ? pr :
                       (lat_kind == `KIND_WR) ? pw : (pr & pw);

    // Next step and finish conditions of each state
    always @* begin
        fin           = 1'b0;
        fcode         = `FLT_NONE;
        paddr         = 52'h0;
        psize         = `PG_4K;
        next_state    = state;
        next_mem_addr = mem_addr;
        next_issue    = 1'b0;
        case (state)
            S_IDLE: begin
                if (req_valid & enable) begin
                    if (|(req_addr >> MAX_IN_W)) begin
                        fin   = 1'b1;
                        fcode = `FLT_WIDTH;
                    end else begin
                        next_mem_addr = {root_base, req_source[15:8], 4'h0};
                        next_issue    = 1'b1;
                        next_state    = S_ROOT;
                    end
                end
            end
            S_ROOT: begin
                if (mem_ack) begin
                    if (mem_err) begin
                        fin   = 1'b1;
                        fcode = `FLT_FETCH;
                    end else if (!mem_rdata[0] | (|mem_rdata[11:1])
                                 | (|(mem_rdata[51:0] & hmask))) begin
                        fin   = 1'b1;
                        fcode = `FLT_ROOT;
                    end else begin
                        next_mem_addr = {mem_rdata[51:12], lat_src[7:0], 4'h0};
                        next_issue    = 1'b1;
                        next_state    = S_CTXL;
                    end
                end
            end
            S_CTXL: begin
                if (mem_ack) begin
                    if (mem_err) begin
                        fin   = 1'b1;
                        fcode = `FLT_FETCH;
                    end else if (!mem_rdata[0] | (|mem_rdata[11:4])
                                 | (mem_rdata[3:2] == `CTX_TT_BLOCK)
                                 | (mem_rdata[3:2] == `CTX_TT_BAD)
                                 | (|(mem_rdata[51:0] & hmask))) begin
                        fin   = 1'b1;
                        fcode = `FLT_CTX;
                    end else begin
                        next_mem_addr = {ctx_ptr, lat_src[7:0], 4'h8};
                        next_issue    = 1'b1;
                        next_state    = S_CTXH;
                    end
                end
            end
            S_CTXH: begin
                if (mem_ack) begin
                    if (mem_err) begin
                        fin   = 1'b1;
                        fcode = `FLT_FETCH;
                    end else if (|mem_rdata[63:24]) begin
                        fin   = 1'b1;
                        fcode = `FLT_CTX;
                    end else begin
                        next_state = S_CHK;
                    end
                end
            end
            S_CHK: begin
                if (!((root_lvl == 4'd3 & CAP_3L) | (root_lvl == 4'd4 & CAP_4L))) begin
                    fin   = 1'b1;
                    fcode = `FLT_CTX;
                end else if (|(lat_addr >> xw)) begin
                    fin   = 1'b1;
                    fcode = `FLT_RANGE;
                end else begin
                    // Three-level walk starts at the level-3 table
                    next_mem_addr = {tbl_root, idx_of(root_lvl[2:0], lat_addr), 3'h0};
                    next_issue    = 1'b1;
                    next_state    = S_WALK;
                end
            end
            S_WALK: begin
                if (mem_ack) begin
                    if (mem_err) begin
                        fin   = 1'b1;
                        fcode = `FLT_FETCH;
                    end else if (!ent_present | ent_rsv) begin
                        fin   = 1'b1;
                        fcode = `FLT_ENTRY;
                    end else if (ent_page) begin
                        fin   = 1'b1;
                        fcode = rights_ok ? `FLT_NONE : `FLT_RIGHTS;
                        case (lvl)
                            3'd3: begin
                                paddr = {mem_rdata[51:30], lat_addr[29:0]};
                                psize = `PG_1G;
                            end
                            3'd2: begin
                                paddr = {mem_rdata[51:21], lat_addr[20:0]};
                                psize = `PG_2M;
                            end
                            default: begin
                                paddr = {mem_rdata[51:12], lat_addr[11:0]};
                                psize = `PG_4K;
                            end
                        endcase
                    end else begin
                        next_mem_addr = {mem_rdata[51:12], idx_of(lvl - 3'd1, lat_addr),
                                         3'h0};
                        next_issue    = 1'b1;
                    end
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // ****************************************
    // Walk state and answer
    // ****************************************
    // A fault ends the walk at once with no further fetch
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state           <= S_IDLE;
            mem_req         <= 1'b0;
            mem_addr        <= 52'h0;
            issue           <= 1'b0;
            lat_addr        <= 64'h0;
            lat_src         <= 16'h0000;
            lat_kind        <= `KIND_RD;
            lat_prs         <= 1'b0;
            ctx_ptr         <= 40'h0;
            tbl_root        <= 40'h0;
            domain_width    <= 7'h00;
            lvl             <= 3'd4;
            perm_r          <= 1'b1;
            perm_w          <= 1'b1;
            rsp_valid       <= 1'b0;
            rsp_addr        <= 52'h0;
            rsp_fault       <= 1'b0;
            rsp_fault_code  <= `FLT_NONE;
            rsp_recoverable <= 1'b0;
            rsp_page_size   <= `PG_4K;
            last_fault      <= `FLT_NONE;
            xl_cnt          <= 32'h0000_0000;
            flt_cnt         <= 32'h0000_0000;
        end else begin
            rsp_valid <= fin;
            issue     <= next_issue;
            mem_addr  <= next_mem_addr;
            // One fetch outstanding, request low one cycle between fetches, two after the S_CTXH fetch
            if (mem_ack) begin
                mem_req <= 1'b0;
            end else if (issue) begin
                mem_req <= 1'b1;
            end
            if (state == S_IDLE && req_valid && enable) begin
                lat_addr <= req_addr;
                lat_src  <= req_source;
                lat_kind <= req_kind;
                lat_prs  <= req_prs;
                perm_r   <= 1'b1;
                perm_w   <= 1'b1;
            end
            if (state == S_ROOT && mem_ack) begin
                ctx_ptr <= mem_rdata[51:12];
            end
            if (state == S_CTXL && mem_ack) begin
                tbl_root <= mem_rdata[51:12];
            end
            if (state == S_CTXH && mem_ack) begin
                domain_width <= mem_rdata[6:0];
            end
            if (state == S_CHK) begin
                lvl <= root_lvl[2:0];
            end
            if (state == S_WALK && mem_ack && next_issue) begin
                lvl    <= lvl - 3'd1;
                perm_r <= pr;
                perm_w <= pw;
            end
            if (fin) begin
                state           <= S_IDLE;
                rsp_addr        <= paddr;
                rsp_fault       <= (fcode != `FLT_NONE);
                rsp_fault_code  <= fcode;
                rsp_page_size   <= psize;
                // Recoverable only when both ends can take a page request
                rsp_recoverable <= (fcode != `FLT_NONE) & CAP_PRS & ctrl[`CTRL_RECOV]
                                   & ((state == S_IDLE) ? req_prs : lat_prs);
                if (fcode == `FLT_NONE) begin
                    xl_cnt <= xl_cnt + 32'h1;
                end else begin
                    flt_cnt    <= flt_cnt + 32'h1;
                    last_fault <= fcode;
                end
            end else begin
                state <= next_state;
            end
        end
    end
endmodule // second_level_page_walker

// >>> verif/walker_assertions.sv
// Port checker for the page walker.
// Assumes it is bound into second_level_page_walker.
`timescale 1ns/1ps
module walker_assertions #(
    parameter [7:0] MAX_IN_W = 8'd48
) (
    // Clock, reset, request and answer
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic [63:0] req_addr,
    input wire logic        rsp_valid,
    input wire logic [51:0] rsp_addr,
    input wire logic        rsp_fault,
    input wire logic [3:0]  rsp_fault_code,
    input wire logic [1:0]  rsp_page_size,
    // Table fetch
    input wire logic        mem_req,
    input wire logic        mem_ack
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [63:0] in_addr;
    logic        ok;
    // Input address of the walk in flight
    always_ff @(posedge hclk)
        if (req_valid && req_ready) in_addr <= req_addr;
    assign ok = rsp_valid && !rsp_fault;
    a_width_fault: assert property (
        req_valid && req_ready && (req_addr >> MAX_IN_W) != 64'h0
        |-> ##[1:2] rsp_valid && rsp_fault && rsp_fault_code == 4'h1) else $error("width fault");
    a_ack_drop: assert property (
        mem_req && mem_ack |=> !mem_req) else $error("fetch held after ack");
    a_fetch_gap: assert property (
        $fell(mem_req) |-> $past(mem_ack)) else $error("fetch ended without ack");
    a_fetch_hold: assert property (
        mem_req && !mem_ack |=> mem_req) else $error("fetch dropped before ack");
    a_stop_after: assert property (
        rsp_valid |-> !mem_req ##1 !mem_req) else $error("fetch after answer");
    a_page_small: assert property (
        ok && rsp_page_size == 2'h0 |-> rsp_addr[11:0] == in_addr[11:0]) else $error("4K offset");
    a_page_mid: assert property (
        ok && rsp_page_size == 2'h1 |-> rsp_addr[20:0] == in_addr[20:0]) else $error("2M offset");
    a_page_big: assert property (
        ok && rsp_page_size == 2'h2 |-> rsp_addr[29:0] == in_addr[29:0]) else $error("1G offset");
endmodule // walker_assertions

bind second_level_page_walker walker_assertions #(.MAX_IN_W(MAX_IN_W)) u_chk (.*);

// >>> verif/table_memory.sv
// Memory model holding the translation tables.
// Assumes one fetch at a time; the bench loads m and err_at.
`timescale 1ns/1ps
module table_memory (
    // Clock and fetch port
    input  wire logic        hclk,
    input  wire logic        mem_req,
    input  wire logic [51:0] mem_addr,
    output logic             mem_ack,
    output logic [63:0]      mem_rdata,
    output logic             mem_err
);
    logic [63:0] m [logic [51:0]];
    logic [51:0] err_at = 52'hF_FFFF_FFFF_FFFF;
    // Answer after 0 to 2 idle cycles; data toggles while idle
    initial begin
        mem_ack = 1'b0;
        mem_err = 1'b0;
        mem_rdata = 64'h0;
        forever begin
            @(posedge hclk);
            if (mem_req && !mem_ack) begin
                repeat ($urandom % 3) @(posedge hclk);
                mem_ack <= 1'b1;
                mem_err <= mem_addr == err_at;
                mem_rdata <= m.exists(mem_addr) ? m[mem_addr] : 64'h0;
            end else begin
                mem_ack <= 1'b0;
                mem_err <= 1'b0;
                mem_rdata <= ~mem_rdata;
            end
        end
    end
endmodule // table_memory

// >>> verif/tb.sv
// Testbench for the page walker: registers, walks and faults.
// Assumes table_memory and walker_assertions are compiled first.
`timescale 1ns/1ps
module tb;
    logic        hclk, hresetn, hsel, hwrite, req_valid, req_prs, recov, mem_req, mem_ack;
    logic        hreadyout, hresp, req_ready, rsp_valid, rsp_fault, rsp_recoverable, mem_err;
    logic [1:0]  htrans, req_kind, rsp_page_size, s;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  rsp_fault_code;
    logic [15:0] req_source;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [51:0] rsp_addr, mem_addr, pg;
    logic [63:0] req_addr, a, mem_rdata;
    wire         hready = hreadyout;
    int          error_cnt, comparisons;
    second_level_page_walker u_dut (.*);
    table_memory u_mem (.*);
    // Clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // Watchdog
    initial begin
        #5000000;
        error_cnt++;
        complete_run();
    end
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 0, hresp);
    endtask
    function automatic logic [51:0] pa(input logic [63:0] x, input logic [1:0] z);
        if (z == 2'h2) return {pg[51:30], x[29:0]};
        if (z == 2'h1) return {pg[51:21], x[20:0]};
        return {pg[51:12], x[11:0]};
    endfunction
    // Request one translation and compare the answer
    task automatic xl(input logic [15:0] src, input logic [63:0] x, input logic [1:0] k,
                      input logic p, input logic [3:0] ec, input logic [51:0] ea);
        @(posedge hclk);
        req_valid <= 1'b1;
        req_addr <= x;
        req_source <= src;
        req_kind <= k;
        req_prs <= p;
        for (int n = 0; n < 500; n++) begin
            @(posedge hclk);
            if (req_ready === 1'b1) break;
        end
        req_valid <= 1'b0;
        for (int n = 0; n < 500; n++) begin
            @(posedge hclk);
            if (rsp_valid === 1'b1) break;
        end
        chk("answer", 1, rsp_valid);
        chk("fault", ec != 4'h0, rsp_fault);
        chk("code", ec, rsp_fault_code);
        chk("addr", ea, rsp_addr);
        chk("recoverable", ec != 4'h0 && p && recov, rsp_recoverable);
        if (ec == 4'h0) chk("size", s, rsp_page_size);
    endtask
    // Four-level tables for address a mapping page pg of size s
    task automatic build(input logic [63:0] lf);
        u_mem.m[52'h10000 | {a[47:39], 3'h0}] = 64'h20003;
        u_mem.m[52'h20000 | {a[38:30], 3'h0}] = s == 2 ? {pg[51:30], 30'h0} | 64'h80 | lf : 64'h30003;
        u_mem.m[52'h30000 | {a[29:21], 3'h0}] = s == 1 ? {pg[51:21], 21'h0} | 64'h80 | lf : 64'h40003;
        u_mem.m[52'h40000 | {a[20:12], 3'h0}] = {pg[51:12], 12'h0} | lf;
    endtask
    // Walk with one entry of level l altered
    task automatic bc(input logic [1:0] z, input int l, input logic [63:0] am, input logic [63:0] om,
                      input logic [1:0] k, input logic [3:0] c);
        logic [51:0] ky;
        s = z;
        build(64'h3);
        ky = 52'h10000 * (5 - l) + 8 * ((a >> (3 + 9 * l)) & 64'h1FF);
        u_mem.m[ky] = u_mem.m[ky] & am | om;
        xl(16'h0, a, k, 1'b0, c, c == 4'h7 ? pa(a, z) : 52'h0);
    endtask
    initial begin
        {hresetn, hsel, hwrite, req_valid, req_prs, recov, htrans, req_kind} = '0;
        {haddr, hwdata, req_source, req_addr} = '0;
        void'($urandom(32'hA347E96B));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b1, 32'h04, 32'h0);
        ahb(1'b0, 32'h04, 32'h0);
        chk("cap", 64'h772E30, rd);
        ahb(1'b0, 32'h40, 32'h0);
        chk("unmapped", 0, rd);
        ahb(1'b0, 32'h00, 32'h0);
        chk("ctrl", 0, rd);
        ahb(1'b1, 32'h08, 32'h1000);
        ahb(1'b1, 32'h00, 32'h1);
        ahb(1'b0, 32'h08, 32'h0);
        chk("root", 64'h1000, rd);
        u_mem.m[52'h1000] = 64'h2001;
        u_mem.m[52'h2000] = 64'h10001;
        u_mem.m[52'h2008] = 64'd48;
        u_mem.m[52'h2010] = 64'h20001;
        u_mem.m[52'h2018] = 64'd39;
        u_mem.m[52'h2020] = 64'h10009;
        u_mem.m[52'h2028] = 64'd48;
        u_mem.m[52'h2030] = 64'h10001;
        u_mem.m[52'h2038] = 64'd30;
        for (int i = 0; i < 40; i++) begin
            a = {$urandom, $urandom} & 64'hFFFF_FFFF_FFFF;
            pg = {$urandom, $urandom} & 52'h3FFF_FFFF_F000;
            s = $urandom % 3;
            build(64'h7);
            xl(16'h0, a, $urandom % 3, 1'b0, 4'h0, pa(a, s));
        end
        s = 2'h0;
        a = a & 64'h7F_FFFF_FFFF;
        build(64'h3);
        xl(16'h1, a, 2'h0, 1'b0, 4'h0, pa(a, 2'h0));
        xl(16'h1, a | 64'h1 << 39, 2'h0, 1'b0, 4'h5, 52'h0);
        xl(16'h0, a | 64'h1 << 48, 2'h0, 1'b0, 4'h1, 52'h0);
        xl(16'h2, a, 2'h0, 1'b0, 4'h4, 52'h0);
        xl(16'h3, a, 2'h0, 1'b0, 4'h4, 52'h0);
        xl(16'h100, a, 2'h0, 1'b0, 4'h3, 52'h0);
        u_mem.err_at = 52'h40000 | {a[20:12], 3'h0};
        xl(16'h0, a, 2'h0, 1'b0, 4'h2, 52'h0);
        u_mem.err_at = '1;
        bc(0, 4, '1, 64'h80, 0, 4'h6);
        bc(0, 2, '1, 64'h800, 0, 4'h6);
        bc(0, 1, '1, 64'h1 << 62, 0, 4'h6);
        bc(0, 1, '1, 64'h1 << 50, 0, 4'h6);
        bc(0, 1, 0, 0, 0, 4'h6);
        bc(0, 3, ~64'h3, 0, 0, 4'h6);
        bc(0, 1, ~64'h2, 0, 1, 4'h7);
        bc(0, 1, ~64'h2, 0, 2, 4'h7);
        bc(2, 3, '1, 64'h1000, 0, 4'h6);
        bc(1, 2, '1, 64'h1000, 0, 4'h6);
        ahb(1'b1, 32'h00, 32'h3);
        recov = 1'b1;
        xl(16'h0, a | 64'h1 << 48, 2'h0, 1'b1, 4'h1, 52'h0);
        xl(16'h2, a, 2'h0, 1'b0, 4'h4, 52'h0);
        complete_run();
    end
endmodule // tb
